/* ifp_regs.vh */
// command codes, field positions and reset values of the input protection commands
`ifndef IFP_REGS_VH
`define IFP_REGS_VH
`define IFP_CMD_VIN_OV_RESP     8'h56
`define IFP_CMD_VIN_UV_LIMIT    8'h59
`define IFP_CMD_VIN_UV_RESP     8'h5A
`define IFP_CMD_IIN_OC_LIMIT    8'h5B
`define IFP_EXP_MSB             15
`define IFP_EXP_LSB             11
`define IFP_MAN_MSB             10
`define IFP_MAN_LSB             0
`define IFP_OV_ACTION_RST       8'h00
`define IFP_UV_ACTION_RST       8'hC0
`define IFP_UV_LIMIT_RST        16'hF80B
`define IFP_OC_LIMIT_RST        16'hF87F
`define IFP_OC_MAN_RST          11'h07F
`define IFP_OC_EXP_FIXED        5'h1F
`define IFP_OC_MAN_MAX          11'h07F
`define IFP_OC_MAN_STEP         11'h010
`define IFP_BYTE_OTHER_BIT      0
`define IFP_WORD_INPUT_BIT      13
`define IFP_IN_OV_BIT           7
`define IFP_IN_UV_BIT           4
`define IFP_IN_OC_BIT           2
`endif

/* ifp_lin_cmp.v */
// compares an unsigned fixed-point measurement against a linear-format limit
module ifp_lin_cmp #(
    parameter MEAS_W = 16,
    parameter FRAC   = 2
) (
    // clock and reset
    input  wire              ref_clk,
    input  wire              sys_rst,
    // limit and measurement
    input  wire [15:0]       limit_word,
    input  wire [MEAS_W-1:0] meas,
    input  wire              meas_valid,
    // result, updated on each measurement
    output reg               above_reg,
    output reg               below_reg
);
    localparam [31:0] FRAC_32 = FRAC;
    wire signed [5:0] exp_s   = {limit_word[15], limit_word[15:11]};
    wire signed [6:0] shift_s = {exp_s[5], exp_s} + FRAC_32[6:0];
    wire [10:0]       man     = limit_word[10:0];
    reg  [47:0]       scaled;
    reg  [6:0]        neg_shift;

    // mantissa times two to the exponent, in measurement units
    always @* begin
        neg_shift = 7'h00;
        if (shift_s[6]) begin
            neg_shift = 7'h00 - shift_s;
            scaled = {37'h0, man} >> neg_shift;
        end else begin
            scaled = {37'h0, man} << shift_s;
        end
    end

    wire [47:0] meas_ext = {{(48-MEAS_W){1'b0}}, meas};

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            above_reg <= 1'b0;
            below_reg <= 1'b0;
        end else if (meas_valid) begin
            above_reg <= meas_ext > scaled; // [R16]
            below_reg <= meas_ext < scaled; // [R16]
        end
    end
endmodule // ifp_lin_cmp

/* ifp_input_fault.v */
// input overvoltage, undervoltage and overcurrent commands with fault reactions
//
// Function
// R1: OV and UV response: single-byte reads only
// R2: UV and OC limits: word access, linear
// R3: one shared copy, page ignored
// R4: OV/UV event sets summary other flag
// R5: OV/UV event sets status word input
// R6: OV/UV set own input status flags
// R7: alert only when mask bit clear
// R8: OV response 00h: flag, alert, keep converting
// R9: UV fault masked until turn-on and enable
// R10: UV limit exponent and mantissa writable, NVM-loaded
// R11: host writes only listed UV encodings; code accepts any UV limit word
// R12: UV response C0h: stop, restart when cleared
// R13: OC limit is input current fault threshold
// R14: OC exponent fixed -1, mantissa 0..127
// R15: turn-on threshold gates UV unmasking
// R16: measurements compared against decoded limits
`include "ifp_regs.vh"

module ifp_input_fault #(
    parameter VIN_W   = 16,
    parameter VIN_FR  = 2,
    parameter IIN_W   = 16,
    parameter IIN_FR  = 1
) (
    // clock and reset
    ref_clk, sys_rst,
    // command port
    cmd_valid, cmd_write, cmd_word, cmd_code, cmd_page, cmd_wdata,
    rsp_valid_reg, rsp_nack_reg, rsp_data_reg,
    // nonvolatile restore
    nvm_load, nvm_uv_limit, nvm_oc_limit,
    // measurements and surrounding configuration
    vin_meas, vin_valid, iin_meas, iin_valid,
    ov_limit, turn_on_threshold, unit_enable_pin,
    alert_mask, clear_faults,
    // status and reactions
    stat_byte_other_reg, stat_word_input_reg, stat_input_reg,
    host_alert_out_reg, uv_conv_stop_reg
);
    input  wire             ref_clk;
    input  wire             sys_rst;
    input  wire             cmd_valid;
    input  wire             cmd_write;
    input  wire             cmd_word;
    input  wire [7:0]       cmd_code;
    input  wire [7:0]       cmd_page;
    input  wire [15:0]      cmd_wdata;
    output reg              rsp_valid_reg;
    output reg              rsp_nack_reg;
    output reg  [15:0]      rsp_data_reg;
    input  wire             nvm_load;
    input  wire [15:0]      nvm_uv_limit;
    input  wire [15:0]      nvm_oc_limit;
    input  wire [VIN_W-1:0] vin_meas;
    input  wire             vin_valid;
    input  wire [IIN_W-1:0] iin_meas;
    input  wire             iin_valid;
    input  wire [15:0]      ov_limit;
    input  wire [15:0]      turn_on_threshold;
    input  wire             unit_enable_pin;
    input  wire [7:0]       alert_mask;
    input  wire             clear_faults;
    output reg              stat_byte_other_reg;
    output reg              stat_word_input_reg;
    output reg  [7:0]       stat_input_reg;
    output reg              host_alert_out_reg;
    output reg              uv_conv_stop_reg;

    reg  [15:0] uv_limit_reg;
    reg  [10:0] oc_man_reg;
    reg         en_meta_reg;
    reg         en_sync_reg;
    reg         uv_armed_reg;
    reg         meas_seen_reg;
    reg  [7:0]  stat_input_next;

    wire        vin_over_ov;
    wire        vin_under_uv;
    wire        vin_over_on;
    wire        iin_over_oc;
    wire [15:0] oc_limit_word = {`IFP_OC_EXP_FIXED, oc_man_reg}; // [R14]
    wire [7:0]  ov_action_field = `IFP_OV_ACTION_RST; // [R8]
    wire [7:0]  uv_action_field = `IFP_UV_ACTION_RST; // [R12]
    wire [10:0] nvm_oc_man = nvm_oc_limit[`IFP_MAN_MSB:`IFP_MAN_LSB];

    // limit comparators: overvoltage, undervoltage, turn-on, overcurrent
    ifp_lin_cmp #(.MEAS_W(VIN_W), .FRAC(VIN_FR)) u_ov (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .limit_word(ov_limit),
        .meas(vin_meas), .meas_valid(vin_valid),
        .above_reg(vin_over_ov), .below_reg());
    ifp_lin_cmp #(.MEAS_W(VIN_W), .FRAC(VIN_FR)) u_uv (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .limit_word(uv_limit_reg),
        .meas(vin_meas), .meas_valid(vin_valid),
        .above_reg(), .below_reg(vin_under_uv));
    ifp_lin_cmp #(.MEAS_W(VIN_W), .FRAC(VIN_FR)) u_on (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .limit_word(turn_on_threshold),
        .meas(vin_meas), .meas_valid(vin_valid),
        .above_reg(vin_over_on), .below_reg());
    ifp_lin_cmp #(.MEAS_W(IIN_W), .FRAC(IIN_FR)) u_oc (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .limit_word(oc_limit_word),
        .meas(iin_meas), .meas_valid(iin_valid),
        .above_reg(iin_over_oc), .below_reg()); // [R13]

    // enable pin comes from outside the clock domain
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_meta_reg <= 1'b0;
            en_sync_reg <= 1'b0;
        end else begin
            en_meta_reg <= unit_enable_pin;
            en_sync_reg <= en_meta_reg;
        end
    end

    // comparator outputs are valid one cycle after the first measurement
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meas_seen_reg <= 1'b0;
        end else if (vin_valid) begin
            meas_seen_reg <= 1'b1;
        end
    end

    wire ov_event = meas_seen_reg && vin_over_ov;
    wire uv_event = meas_seen_reg && uv_armed_reg && vin_under_uv; // [R9]
    wire oc_event = iin_over_oc;

    // undervoltage unmask latches once input passed turn-on while enabled
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            uv_armed_reg <= 1'b0;
        end else if (meas_seen_reg && vin_over_on && en_sync_reg) begin
            uv_armed_reg <= 1'b1; // [R9] [R15]
        end
    end

    // sticky input status bits; a new event wins over a clear
    always @* begin
        stat_input_next = clear_faults ? 8'h00 : stat_input_reg;
        if (ov_event) begin
            stat_input_next[`IFP_IN_OV_BIT] = 1'b1; // [R6]
        end
        if (uv_event) begin
            stat_input_next[`IFP_IN_UV_BIT] = 1'b1; // [R6]
        end
        if (oc_event) begin
            stat_input_next[`IFP_IN_OC_BIT] = 1'b1;
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_input_reg      <= 8'h00;
            stat_byte_other_reg <= 1'b0;
            stat_word_input_reg <= 1'b0;
            host_alert_out_reg  <= 1'b0;
            uv_conv_stop_reg    <= 1'b0;
        end else begin
            stat_input_reg      <= stat_input_next; // [R6]
            stat_byte_other_reg <= |stat_input_next; // [R4]
            stat_word_input_reg <= |stat_input_next; // [R5]
            host_alert_out_reg  <= |(stat_input_next & ~alert_mask); // [R7]
            // overvoltage action never stops conversion [R8]
            uv_conv_stop_reg    <= uv_event && (uv_action_field == `IFP_UV_ACTION_RST); // [R12]
        end
    end

    // command decoding; page is ignored since every command is shared [R3]
    wire hit_ov_resp  = cmd_code == `IFP_CMD_VIN_OV_RESP;
    wire hit_uv_resp  = cmd_code == `IFP_CMD_VIN_UV_RESP;
    wire hit_uv_limit = cmd_code == `IFP_CMD_VIN_UV_LIMIT;
    wire hit_oc_limit = cmd_code == `IFP_CMD_IIN_OC_LIMIT;
    wire byte_ok  = (hit_ov_resp || hit_uv_resp) && !cmd_write && !cmd_word; // [R1]
    wire word_ok  = (hit_uv_limit || hit_oc_limit) && cmd_word; // [R2]
    wire oc_man_ok = cmd_wdata[`IFP_MAN_MSB:`IFP_MAN_LSB] <= `IFP_OC_MAN_MAX; // [R14]
    wire cmd_ok   = byte_ok || (word_ok && !(cmd_write && hit_oc_limit && !oc_man_ok));
    wire nvm_oc_listed = (nvm_oc_man == `IFP_OC_MAN_MAX) ||
                         ((nvm_oc_man[3:0] == 4'h0) && (nvm_oc_man != 11'h000) &&
                          (nvm_oc_man < (`IFP_OC_MAN_STEP << 3)));

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            uv_limit_reg <= `IFP_UV_LIMIT_RST;
            oc_man_reg   <= `IFP_OC_MAN_RST;
        end else if (nvm_load) begin
            uv_limit_reg <= nvm_uv_limit; // [R10]
            oc_man_reg   <= nvm_oc_listed ? nvm_oc_man : `IFP_OC_MAN_MAX;
        end else if (cmd_valid && cmd_write && cmd_ok) begin
            if (hit_uv_limit) begin
                uv_limit_reg <= cmd_wdata; // [R10] [R2] [R3]
            end
            if (hit_oc_limit) begin
                oc_man_reg <= cmd_wdata[`IFP_MAN_MSB:`IFP_MAN_LSB]; // [R14] [R3]
            end
        end
    end

    // answer one cycle after each command
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid_reg <= 1'b0;
            rsp_nack_reg  <= 1'b0;
            rsp_data_reg  <= 16'h0000;
        end else begin
            rsp_valid_reg <= cmd_valid;
            rsp_nack_reg  <= cmd_valid && !cmd_ok; // [R1]
            rsp_data_reg  <= 16'h0000;
            if (cmd_valid && !cmd_write && cmd_ok) begin
                case (cmd_code)
                    `IFP_CMD_VIN_OV_RESP:  rsp_data_reg <= {8'h00, ov_action_field};
                    `IFP_CMD_VIN_UV_RESP:  rsp_data_reg <= {8'h00, uv_action_field};
                    `IFP_CMD_VIN_UV_LIMIT: rsp_data_reg <= uv_limit_reg;
                    `IFP_CMD_IIN_OC_LIMIT: rsp_data_reg <= oc_limit_word;
                    default:               rsp_data_reg <= 16'h0000;
                endcase
            end
        end
    end
endmodule // ifp_input_fault

/* ifp_input_fault_monitor.sv */
// concurrent checks on the command port and the status outputs
module ifp_input_fault_monitor #(
    parameter VIN_W = 16
) (
    // clock and reset
    input logic             ref_clk,
    input logic             sys_rst,
    // command port
    input logic             cmd_valid,
    input logic             cmd_write,
    input logic             cmd_word,
    input logic [7:0]       cmd_code,
    input logic             rsp_valid_reg,
    input logic             rsp_nack_reg,
    input logic [15:0]      rsp_data_reg,
    // measurement and status
    input logic [VIN_W-1:0] vin_meas,
    input logic             vin_valid,
    input logic [15:0]      ov_limit,
    input logic [7:0]       alert_mask,
    input logic             stat_byte_other_reg,
    input logic             stat_word_input_reg,
    input logic [7:0]       stat_input_reg,
    input logic             host_alert_out_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    resp_timing_a: assert property (cmd_valid |=> rsp_valid_reg)
        else $error("no answer one cycle after command");
    ro_write_a: assert property (cmd_valid && cmd_write && (cmd_code == 8'h56 ||
        cmd_code == 8'h5A) |=> rsp_nack_reg) else $error("write to action code taken");
    word_only_a: assert property (cmd_valid && !cmd_word && (cmd_code == 8'h59 ||
        cmd_code == 8'h5B) |=> rsp_nack_reg) else $error("byte access to limit taken");
    ov_action_a: assert property (cmd_valid && !cmd_write && !cmd_word &&
        cmd_code == 8'h56 |=> !rsp_nack_reg && rsp_data_reg == 16'h0000)
        else $error("overvoltage action code wrong");
    uv_action_a: assert property (cmd_valid && !cmd_write && !cmd_word &&
        cmd_code == 8'h5A |=> !rsp_nack_reg && rsp_data_reg == 16'h00C0)
        else $error("undervoltage action code wrong");
    oc_exponent_a: assert property (cmd_valid && !cmd_write && cmd_word &&
        cmd_code == 8'h5B |=> rsp_data_reg[15:11] == 5'h1F) else $error("oc exponent wrong");
    ov_flag_a: assert property (vin_valid && ov_limit[15:11] == 5'h00 &&
        vin_meas > {ov_limit[10:0], 2'b00} |=> ##1 stat_input_reg[7])
        else $error("overvoltage flag missing");
    summary_a: assert property (stat_byte_other_reg == (|stat_input_reg) &&
        stat_word_input_reg == stat_byte_other_reg) else $error("summary flags wrong");
    alert_mask_a: assert property ($stable(alert_mask) |->
        host_alert_out_reg == (|(stat_input_reg & ~alert_mask))) else $error("alert wrong");
endmodule // ifp_input_fault_monitor

/* ifp_host_model.sv */
// host side model: issues one command transfer at a time
module ifp_host_model (
    // clock
    input  logic        ref_clk,
    // command port
    output logic        cmd_valid,
    output logic        cmd_write,
    output logic        cmd_word,
    output logic [7:0]  cmd_code,
    output logic [7:0]  cmd_page,
    output logic [15:0] cmd_wdata,
    input  logic        rsp_valid_reg,
    input  logic        rsp_nack_reg,
    input  logic [15:0] rsp_data_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cmd_valid, cmd_write, cmd_word, cmd_code, cmd_page, cmd_wdata} = '0;
    end
    // byte or word kind is chosen by the caller per command
    task automatic xfer(input logic wr, input logic wd, input logic [7:0] code,
                        input logic [15:0] data, output logic [15:0] rd, output logic nk);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_word  = wd;
        cmd_code  = code;
        cmd_wdata = data;
        cmd_page  = ~cmd_page;
        @(negedge ref_clk);
        rd = rsp_valid_reg ? rsp_data_reg : 16'hXXXX;
        nk = rsp_valid_reg ? rsp_nack_reg : 1'bX;
        cmd_valid = 1'b0;
        cmd_code  = ~cmd_code;
        cmd_wdata = ~cmd_wdata;
    endtask
endmodule // ifp_host_model

/* ifp_input_fault_tb_top.sv */
// testbench for the input protection commands and fault reactions
module ifp_input_fault_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, sys_rst, cmd_valid, cmd_write, cmd_word, rsp_valid_reg, rsp_nack_reg;
    logic        nvm_load, vin_valid, iin_valid, unit_enable_pin, clear_faults, nk;
    logic        stat_byte_other_reg, stat_word_input_reg, host_alert_out_reg, uv_conv_stop_reg;
    logic [7:0]  cmd_code, cmd_page, alert_mask, stat_input_reg;
    logic [15:0] cmd_wdata, rsp_data_reg, nvm_uv_limit, nvm_oc_limit, vin_meas, iin_meas, rd;
    logic [15:0] ov_limit, turn_on_threshold;
    logic [15:0] uv_tab [8] = '{16'hF011, 16'hF80B, 16'hF80D, 16'hF80F,
                                16'hF811, 16'hF813, 16'hF815, 16'hF817};
    int          n_fail, check_count;
    ifp_host_model i_ifp_host_model (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_word(cmd_word), .cmd_code(cmd_code), .cmd_page(cmd_page),
        .cmd_wdata(cmd_wdata), .rsp_valid_reg(rsp_valid_reg), .rsp_nack_reg(rsp_nack_reg),
        .rsp_data_reg(rsp_data_reg));
    ifp_input_fault i_ifp_input_fault (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_word(cmd_word),
        .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata),
        .rsp_valid_reg(rsp_valid_reg), .rsp_nack_reg(rsp_nack_reg), .rsp_data_reg(rsp_data_reg),
        .nvm_load(nvm_load), .nvm_uv_limit(nvm_uv_limit), .nvm_oc_limit(nvm_oc_limit),
        .vin_meas(vin_meas), .vin_valid(vin_valid), .iin_meas(iin_meas), .iin_valid(iin_valid),
        .ov_limit(ov_limit), .turn_on_threshold(turn_on_threshold),
        .unit_enable_pin(unit_enable_pin), .alert_mask(alert_mask), .clear_faults(clear_faults),
        .stat_byte_other_reg(stat_byte_other_reg), .stat_word_input_reg(stat_word_input_reg),
        .stat_input_reg(stat_input_reg), .host_alert_out_reg(host_alert_out_reg),
        .uv_conv_stop_reg(uv_conv_stop_reg));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic wr, input logic wd, input logic [7:0] c,
                       input logic [15:0] d, input logic [15:0] exp, input logic enk);
        i_ifp_host_model.xfer(wr, wd, c, d, rd, nk);
        chk({15'h0000, nk}, {15'h0000, enk});
        if (!enk && !wr) chk(rd, exp);
    endtask
    // one measurement, status checked two cycles after it is taken
    task automatic samp(input logic cur, input logic [15:0] v, input logic [7:0] es,
                        input logic stop);
        @(negedge ref_clk);
        if (cur) {iin_meas, iin_valid} = {v, 1'b1};
        else {vin_meas, vin_valid} = {v, 1'b1};
        @(negedge ref_clk);
        {iin_valid, vin_valid} = 2'b00;
        @(negedge ref_clk);
        chk({8'h00, stat_input_reg}, {8'h00, es});
        chk({12'h000, stat_byte_other_reg, stat_word_input_reg, host_alert_out_reg,
             uv_conv_stop_reg}, {12'h000, |es, |es, |es, stop});
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        n_fail++;
        summarize;
    end
    initial begin
        {sys_rst, nvm_load, vin_valid, iin_valid, unit_enable_pin, clear_faults} = 6'h20;
        {nvm_uv_limit, nvm_oc_limit, vin_meas, iin_meas, alert_mask} = '0;
        ov_limit = 16'h0010;
        turn_on_threshold = 16'hF010;
        repeat (8) @(negedge ref_clk);
        sys_rst = 1'b0;
        cmd(0, 0, 8'h56, 0, 16'h0000, 0);
        cmd(0, 0, 8'h5A, 0, 16'h00C0, 0);
        cmd(0, 1, 8'h59, 0, 16'hF80B, 0);
        cmd(0, 1, 8'h5B, 0, 16'hF87F, 0);
        cmd(1, 0, 8'h56, 16'h0055, 0, 1);
        cmd(1, 0, 8'h5A, 16'h0055, 0, 1);
        cmd(0, 1, 8'h5A, 0, 0, 1);
        cmd(0, 0, 8'h59, 0, 0, 1);
        cmd(0, 0, 8'h5B, 0, 0, 1);
        foreach (uv_tab[i]) begin
            cmd(1, 1, 8'h59, uv_tab[i], 0, 0);
            cmd(0, 1, 8'h59, 0, uv_tab[i], 0);
        end
        cmd(1, 1, 8'h5B, 16'hF850, 0, 0);
        cmd(1, 1, 8'h5B, 16'hF880, 0, 1);
        cmd(0, 1, 8'h5B, 0, 16'hF850, 0);
        samp(1, 16'd80, 8'h00, 0);
        samp(1, 16'd81, 8'h04, 0);
        samp(0, 16'd10, 8'h04, 0);
        unit_enable_pin = 1'b1;
        repeat (3) @(negedge ref_clk);
        samp(0, 16'd50, 8'h04, 0);
        samp(0, 16'd45, 8'h14, 1);
        samp(0, 16'd46, 8'h14, 0);
        samp(0, 16'd65, 8'h94, 0);
        alert_mask = 8'h94;
        repeat (2) @(negedge ref_clk);
        chk({15'h0000, host_alert_out_reg}, 16'h0000);
        alert_mask = 8'h14;
        repeat (2) @(negedge ref_clk);
        chk({15'h0000, host_alert_out_reg}, 16'h0001);
        // bring both inputs back inside their limits so the clear is not re-raised
        samp(0, 16'd50, 8'h94, 0);
        samp(1, 16'd10, 8'h94, 0);
        clear_faults = 1'b1;
        @(negedge ref_clk);
        clear_faults = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk({8'h00, stat_input_reg}, 16'h0000);
        chk({15'h0000, host_alert_out_reg}, 16'h0000);
        {nvm_uv_limit, nvm_oc_limit, nvm_load} = {16'hF811, 16'hF845, 1'b1};
        @(negedge ref_clk);
        nvm_load = 1'b0;
        cmd(0, 1, 8'h59, 0, 16'hF811, 0);
        cmd(0, 1, 8'h5B, 0, 16'hF87F, 0);
        {nvm_uv_limit, nvm_oc_limit, nvm_load} = {16'hF80D, 16'hF830, 1'b1};
        @(negedge ref_clk);
        nvm_load = 1'b0;
        cmd(0, 1, 8'h59, 0, 16'hF80D, 0);
        cmd(0, 1, 8'h5B, 0, 16'hF830, 0);
        summarize;
    end
endmodule // ifp_input_fault_tb_top
bind ifp_input_fault ifp_input_fault_monitor #(.VIN_W(VIN_W)) i_ifp_input_fault_monitor (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_word(cmd_word), .cmd_code(cmd_code), .rsp_valid_reg(rsp_valid_reg),
    .rsp_nack_reg(rsp_nack_reg), .rsp_data_reg(rsp_data_reg), .vin_meas(vin_meas),
    .vin_valid(vin_valid), .ov_limit(ov_limit), .alert_mask(alert_mask),
    .stat_byte_other_reg(stat_byte_other_reg), .stat_word_input_reg(stat_word_input_reg),
    .stat_input_reg(stat_input_reg), .host_alert_out_reg(host_alert_out_reg));
